/* design/pius_pkg.sv */
// Shared constants and types for the parameter image upload link
package pius_pkg;

	// ==========================================================
	// Command encoding
	localparam logic [7:0]  PIUS_CMD_MEM_RD    = 8'h1D; // Memory-read code
	localparam logic [7:0]  PIUS_MODE_RAM_LONG = 8'h13; // RAM area, long size
	localparam logic [15:0] PIUS_SIZE_ONE      = 16'h0001; // One element

	// ==========================================================
	// Virtual address map
	localparam logic [31:0] PIUS_ADDR_LEN  = 32'h8001F000; // Length word
	localparam logic [31:0] PIUS_ADDR_DATA = 32'h8001F020; // Area base
	localparam logic [31:0] PIUS_ADDR_STEP = 32'h00000004; // Long word step
	localparam logic [1:0]  PIUS_ALIGN_OK  = 2'h0;         // Low bits aligned

	// ==========================================================
	// Image storage
	localparam int          PIUS_IDX_W     = 10;           // Long word index
	localparam int          PIUS_MEM_WORDS = 1 << PIUS_IDX_W;
	localparam logic [15:0] PIUS_LEN_RESET = 16'h0000;     // Empty image

	// ==========================================================
	// Timing
	localparam int          PIUS_CLK_KHZ    = 250000;      // mclk rate
	localparam int          PIUS_TIMEOUT_MS = 200;         // Longest processing
	localparam int          PIUS_TIMEOUT_CYC = PIUS_TIMEOUT_MS * PIUS_CLK_KHZ;
	localparam int          PIUS_TMR_W      = 26;
	localparam logic [2:0]  PIUS_RSP_LAT    = 3'h4;        // Drive reply delay

	// ==========================================================
	// Host sequencer states
	typedef enum logic [2:0] {
		PIUS_H_IDLE  = 3'h0,
		PIUS_H_SVOFF = 3'h1,
		PIUS_H_ISSUE = 3'h2,
		PIUS_H_WAIT  = 3'h3
	} pius_hstate_t;

	// Drive responder states
	typedef enum logic [1:0] {
		PIUS_D_IDLE = 2'h0,
		PIUS_D_READ = 2'h1,
		PIUS_D_RESP = 2'h2
	} pius_dstate_t;

endpackage

/* design/pius_link_if.sv */
// Command/response link between host sequencer and drive
`timescale 1ns/10ps
`default_nettype none
interface pius_link_if;
	logic        cmd_valid;     // Command strobe
	logic [7:0]  cmd_code;      // First command byte
	logic [7:0]  cmd_mode;      // Access-kind selector
	logic [15:0] cmd_size;      // Element count
	logic [31:0] cmd_addr;      // Virtual address
	logic        servo_off_cmd; // Host requests servo off
	logic        rsp_valid;     // Response strobe
	logic [7:0]  response_command_code; // Echoed code
	logic        command_ready_flag;    // Drive ready
	logic        rsp_error;     // Command failed
	logic [31:0] rsp_data;      // Long word read
	logic        servo_on;      // Drive servo state

	modport host (
		output cmd_valid, cmd_code, cmd_mode, cmd_size, cmd_addr,
		output servo_off_cmd,
		input  rsp_valid, response_command_code, command_ready_flag,
		input  rsp_error, rsp_data, servo_on
	);
	modport drive (
		input  cmd_valid, cmd_code, cmd_mode, cmd_size, cmd_addr,
		input  servo_off_cmd,
		output rsp_valid, response_command_code, command_ready_flag,
		output rsp_error, rsp_data, servo_on
	);
endinterface
`default_nettype wire

/* design/pius_drive.sv */
// Drive end: parameter image held as virtual memory, answers memory reads
`timescale 1ns/10ps
`default_nettype none
module pius_drive
	import pius_pkg::*;
(
	input  wire logic                  mclk,        // Clock
	input  wire logic                  rst_n,       // Async reset, low
	pius_link_if.drive                 lnk,         // Link to host
	input  wire logic                  img_wr_en,   // Load one image word
	input  wire logic [PIUS_IDX_W-1:0] img_wr_idx,  // Long word index
	input  wire logic [31:0]           img_wr_data, // Long word value
	input  wire logic                  len_wr_en,   // Load image length
	input  wire logic [15:0]           len_wr_data, // Length in 16-bit words
	input  wire logic                  servo_on_req // Turn servo on
);

	// ==========================================================
	// Storage
	logic [31:0]           image_mem [PIUS_MEM_WORDS];
	logic [31:0]           rd_word;
	logic [15:0]           img_len;
	logic [15:0]           next_img_len;
	pius_dstate_t          state;
	pius_dstate_t          next_state;
	logic [2:0]            lat;
	logic [2:0]            next_lat;
	logic [PIUS_IDX_W-1:0] cap_idx;
	logic [PIUS_IDX_W-1:0] next_cap_idx;
	logic                  cap_len;
	logic                  next_cap_len;
	logic                  cap_err;
	logic                  next_cap_err;
	logic                  servo;
	logic                  next_servo;
	logic                  rsp_v;
	logic                  next_rsp_v;
	logic [7:0]            rsp_code;
	logic [7:0]            next_rsp_code;
	logic                  rdy;
	logic                  next_rdy;
	logic                  rsp_e;
	logic                  next_rsp_e;
	logic [31:0]           rsp_d;
	logic [31:0]           next_rsp_d;
	logic [31:0]           off;
	logic [31:0]           words;

	// Image memory: user loads, link reads whole long words
	always_ff @(posedge mclk) begin
		if (img_wr_en) begin
			image_mem[img_wr_idx] <= img_wr_data;
		end
		rd_word <= image_mem[cap_idx];
	end

	// Offset into data area and its long word count
	assign off   = lnk.cmd_addr - PIUS_ADDR_DATA;
	assign words = {17'h00000, img_len[15:1]};

	// Decode, wait, answer
	always_comb begin
		next_state    = state;
		next_lat      = lat;
		next_cap_idx  = cap_idx;
		next_cap_len  = cap_len;
		next_cap_err  = cap_err;
		next_rsp_v    = 1'b0;
		next_rsp_code = rsp_code;
		next_rdy      = rdy;
		next_rsp_e    = rsp_e;
		next_rsp_d    = rsp_d;
		next_img_len  = len_wr_en ? len_wr_data : img_len;
		next_servo    = servo;
		if (servo_on_req) begin
			next_servo = 1'b1;
		end
		if (lnk.servo_off_cmd) begin
			next_servo = 1'b0;
		end
		unique case (state)
			PIUS_D_IDLE: begin
				if (lnk.cmd_valid) begin
					next_state    = PIUS_D_READ;
					next_lat      = PIUS_RSP_LAT;
					next_rdy      = 1'b0;
					next_rsp_code = lnk.cmd_code;
					next_cap_len  = (lnk.cmd_addr == PIUS_ADDR_LEN);
					next_cap_idx  = off[PIUS_IDX_W+1:2];
					next_cap_err  = (lnk.cmd_code != PIUS_CMD_MEM_RD)
						|| (lnk.cmd_mode != PIUS_MODE_RAM_LONG)
						|| (lnk.cmd_size != PIUS_SIZE_ONE)
						|| servo;
					if (lnk.cmd_addr != PIUS_ADDR_LEN) begin
						if ((lnk.cmd_addr < PIUS_ADDR_DATA)
							|| (off[1:0] != PIUS_ALIGN_OK)
							|| ((off >> 2) >= words)
							|| ((off >> 2) >= PIUS_MEM_WORDS)) begin
							next_cap_err = 1'b1;
						end
					end
				end
			end
			PIUS_D_READ: begin
				next_lat = lat - 3'h1;
				if (lat == 3'h1) begin
					next_state = PIUS_D_RESP;
				end
			end
			PIUS_D_RESP: begin
				next_state = PIUS_D_IDLE;
				next_rsp_v = 1'b1;
				next_rdy   = 1'b1;
				next_rsp_e = cap_err;
				if (cap_err) begin
					next_rsp_d = 32'h00000000;
				end else if (cap_len) begin
					next_rsp_d = {16'h0000, img_len};
				end else begin
					next_rsp_d = rd_word;
				end
			end
			default: begin
				next_state = PIUS_D_IDLE;
			end
		endcase
	end

	// State and response registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= PIUS_D_IDLE;
			lat      <= 3'h0;
			cap_idx  <= '0;
			cap_len  <= 1'b0;
			cap_err  <= 1'b0;
			img_len  <= PIUS_LEN_RESET;
			servo    <= 1'b0;
			rsp_v    <= 1'b0;
			rsp_code <= 8'h00;
			rdy      <= 1'b1;
			rsp_e    <= 1'b0;
			rsp_d    <= 32'h00000000;
		end else begin
			state    <= next_state;
			lat      <= next_lat;
			cap_idx  <= next_cap_idx;
			cap_len  <= next_cap_len;
			cap_err  <= next_cap_err;
			img_len  <= next_img_len;
			servo    <= next_servo;
			rsp_v    <= next_rsp_v;
			rsp_code <= next_rsp_code;
			rdy      <= next_rdy;
			rsp_e    <= next_rsp_e;
			rsp_d    <= next_rsp_d;
		end
	end

	// Link outputs
	assign lnk.rsp_valid             = rsp_v;
	assign lnk.response_command_code = rsp_code;
	assign lnk.command_ready_flag    = rdy;
	assign lnk.rsp_error             = rsp_e;
	assign lnk.rsp_data              = rsp_d;
	assign lnk.servo_on              = servo;

endmodule
`default_nettype wire

/* design/pius_host.sv */
// Host end: sequencer that uploads the drive's parameter image
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Memory-read code 1D sent and echoed
// - Access kind 13 hex on every read
// - Drive returns only whole long words
// - First read length word at 8001F000
// - Then read area from 8001F020 onward
// - Address advances by four after each good area read
// - Done when code echoed and ready set
// - Retry failed read once, then abort
// - Servo switched off before any upload
// - Drive parameters form virtual memory space
// - Area spans about two thousand words
// - Spindle drive image holds motor parameters
module pius_host
	import pius_pkg::*;
#(
	parameter int TIMEOUT_CYC = PIUS_TIMEOUT_CYC // Response wait limit
)
(
	input  wire logic        mclk,         // Clock
	input  wire logic        rst_n,        // Async reset, low
	pius_link_if.host        lnk,          // Link to drive
	input  wire logic        start,        // Begin upload, pulse
	output logic             busy,         // Upload running
	output logic             done,         // Upload finished, pulse
	output logic             aborted,      // Upload given up, pulse
	output logic             word_valid,   // Image word strobe
	output logic [31:0]      word_data,    // Image word
	output logic [15:0]      word_index,   // Long word number
	output logic [15:0]      image_length  // Length in 16-bit words
);

	// ==========================================================
	// Sequencer state
	localparam logic [PIUS_TMR_W-1:0] TMR_LAST =
		PIUS_TMR_W'(TIMEOUT_CYC - 1);

	pius_hstate_t          state;
	pius_hstate_t          next_state;
	logic                  phase_data;
	logic                  next_phase_data;
	logic                  retry;
	logic                  next_retry;
	logic [31:0]           addr;
	logic [31:0]           next_addr;
	logic [15:0]           remain;
	logic [15:0]           next_remain;
	logic [PIUS_TMR_W-1:0] tmr;
	logic [PIUS_TMR_W-1:0] next_tmr;
	logic                  cmd_v;
	logic                  next_cmd_v;
	logic                  svoff;
	logic                  next_svoff;
	logic                  next_busy;
	logic                  next_done;
	logic                  next_aborted;
	logic                  next_word_valid;
	logic [31:0]           next_word_data;
	logic [15:0]           next_word_index;
	logic [15:0]           next_image_length;
	logic                  rsp_ok;
	logic                  rsp_bad;

	// Response judgement
	assign rsp_ok  = lnk.rsp_valid && !lnk.rsp_error
		&& (lnk.response_command_code == PIUS_CMD_MEM_RD)
		&& lnk.command_ready_flag;
	assign rsp_bad = (lnk.rsp_valid && !rsp_ok) || (tmr == TMR_LAST);

	// Next-state logic of the upload sequence
	always_comb begin
		next_state        = state;
		next_phase_data   = phase_data;
		next_retry        = retry;
		next_addr         = addr;
		next_remain       = remain;
		next_tmr          = tmr;
		next_cmd_v        = 1'b0;
		next_svoff        = svoff;
		next_busy         = busy;
		next_done         = 1'b0;
		next_aborted      = 1'b0;
		next_word_valid   = 1'b0;
		next_word_data    = word_data;
		next_word_index   = word_index;
		next_image_length = image_length;
		unique case (state)
			PIUS_H_IDLE: begin
				if (start) begin
					next_state = PIUS_H_SVOFF;
					next_busy  = 1'b1;
					next_svoff = 1'b1;
				end
			end
			PIUS_H_SVOFF: begin
				// Hold off until the drive reports servo off
				if (!lnk.servo_on) begin
					next_state      = PIUS_H_ISSUE;
					next_phase_data = 1'b0;
					next_retry      = 1'b0;
					next_addr       = PIUS_ADDR_LEN;
					next_word_index = 16'h0000;
				end
			end
			PIUS_H_ISSUE: begin
				next_cmd_v = 1'b1;
				next_tmr   = '0;
				next_state = PIUS_H_WAIT;
			end
			PIUS_H_WAIT: begin
				next_tmr = tmr + 1'b1;
				if (rsp_ok) begin
					next_retry = 1'b0;
					if (!phase_data) begin
						next_image_length = lnk.rsp_data[15:0];
						next_remain = {1'b0, lnk.rsp_data[15:1]};
						next_addr   = PIUS_ADDR_DATA;
						next_phase_data = 1'b1;
						if (lnk.rsp_data[15:1] == 15'h0000) begin
							next_state = PIUS_H_IDLE;
							next_busy  = 1'b0;
							next_done  = 1'b1;
							next_svoff = 1'b0;
						end else begin
							next_state = PIUS_H_ISSUE;
						end
					end else begin
						next_word_valid = 1'b1;
						next_word_data  = lnk.rsp_data;
						next_word_index = word_index + 16'h0001;
						next_remain     = remain - 16'h0001;
						next_addr       = addr + PIUS_ADDR_STEP;
						if (remain == 16'h0001) begin
							next_state = PIUS_H_IDLE;
							next_busy  = 1'b0;
							next_done  = 1'b1;
							next_svoff = 1'b0;
						end else begin
							next_state = PIUS_H_ISSUE;
						end
					end
				end else if (rsp_bad) begin
					if (!retry) begin
						next_retry = 1'b1;
						next_state = PIUS_H_ISSUE;
					end else begin
						next_state   = PIUS_H_IDLE;
						next_busy    = 1'b0;
						next_aborted = 1'b1;
						next_svoff   = 1'b0;
					end
				end
			end
			default: begin
				next_state = PIUS_H_IDLE;
				next_busy  = 1'b0;
				next_svoff = 1'b0;
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state        <= PIUS_H_IDLE;
			phase_data   <= 1'b0;
			retry        <= 1'b0;
			addr         <= 32'h00000000;
			remain       <= 16'h0000;
			tmr          <= '0;
			cmd_v        <= 1'b0;
			svoff        <= 1'b0;
			busy         <= 1'b0;
			done         <= 1'b0;
			aborted      <= 1'b0;
			word_valid   <= 1'b0;
			word_data    <= 32'h00000000;
			word_index   <= 16'h0000;
			image_length <= 16'h0000;
		end else begin
			state        <= next_state;
			phase_data   <= next_phase_data;
			retry        <= next_retry;
			addr         <= next_addr;
			remain       <= next_remain;
			tmr          <= next_tmr;
			cmd_v        <= next_cmd_v;
			svoff        <= next_svoff;
			busy         <= next_busy;
			done         <= next_done;
			aborted      <= next_aborted;
			word_valid   <= next_word_valid;
			word_data    <= next_word_data;
			word_index   <= next_word_index;
			image_length <= next_image_length;
		end
	end

	// ==========================================================
	// Command fields toward the drive
	assign lnk.cmd_valid     = cmd_v;
	assign lnk.cmd_code      = PIUS_CMD_MEM_RD;
	assign lnk.cmd_mode      = PIUS_MODE_RAM_LONG;
	assign lnk.cmd_size      = PIUS_SIZE_ONE;
	assign lnk.cmd_addr      = addr;
	assign lnk.servo_off_cmd = svoff;

endmodule
`default_nettype wire

/* tb/pius_link_asserts.sv */
// Checker for the upload command/response link
`timescale 1ns/10ps
`default_nettype none
module pius_link_asserts
	import pius_pkg::*;
(
	input wire logic        mclk,                  // Clock
	input wire logic        rst_n,                 // Async reset, low
	input wire logic        cmd_valid,             // Command strobe
	input wire logic [7:0]  cmd_code,              // Command code
	input wire logic [7:0]  cmd_mode,              // Access kind
	input wire logic [15:0] cmd_size,              // Element count
	input wire logic [31:0] cmd_addr,              // Virtual address
	input wire logic        servo_off_cmd,         // Servo off request
	input wire logic        rsp_valid,             // Response strobe
	input wire logic [7:0]  response_command_code, // Echoed code
	input wire logic        command_ready_flag,    // Drive ready
	input wire logic        rsp_error,             // Command failed
	input wire logic        servo_on               // Servo state
);
	// ==========================================================
	// Helper state
	logic [31:0] last_addr;      // Last issued address
	logic [1:0]  err_run;        // Failures in a row
	logic [31:0] next_last_addr;
	logic [1:0]  next_err_run;

	// Track last address and failure run
	always_comb begin
		next_last_addr = cmd_valid ? cmd_addr : last_addr;
		next_err_run   = err_run;
		if (rsp_valid && !rsp_error) begin
			next_err_run = 2'h0;
		end else if (rsp_valid && (err_run != 2'h2)) begin
			next_err_run = err_run + 2'h1;
		end
	end

	// Register helper state
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			last_addr <= 32'h0;
			err_run <= 2'h0;
		end else begin
			last_addr <= next_last_addr;
			err_run <= next_err_run;
		end
	end

	// ==========================================================
	// Properties
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_code_sent: assert property (cmd_valid |->
		cmd_code == PIUS_CMD_MEM_RD)
		else $error("command code wrong");
	a_echo_code: assert property (rsp_valid |->
		response_command_code == PIUS_CMD_MEM_RD && command_ready_flag)
		else $error("response code or ready wrong");
	a_mode_size: assert property (cmd_valid |->
		cmd_mode == PIUS_MODE_RAM_LONG && cmd_size == PIUS_SIZE_ONE)
		else $error("mode or size wrong");
	a_answer_time: assert property (cmd_valid && command_ready_flag
		|=> !command_ready_flag [*5] ##1 (rsp_valid && command_ready_flag))
		else $error("answer timing wrong");
	a_one_pending: assert property (cmd_valid |=> !cmd_valid [*7])
		else $error("command issued too soon");
	a_servo_off: assert property (cmd_valid |->
		servo_off_cmd && !servo_on)
		else $error("read with servo on");
	a_retry_same: assert property (cmd_valid && err_run == 2'h1 |->
		cmd_addr == last_addr)
		else $error("retry address changed");
	a_addr_step: assert property (cmd_valid && err_run == 2'h0
		&& last_addr >= PIUS_ADDR_DATA
		|-> cmd_addr == last_addr + PIUS_ADDR_STEP || cmd_addr == PIUS_ADDR_LEN)
		else $error("address step wrong");
	a_area_base: assert property (cmd_valid && err_run == 2'h0
		&& last_addr == PIUS_ADDR_LEN
		|-> cmd_addr == PIUS_ADDR_DATA || cmd_addr == PIUS_ADDR_LEN)
		else $error("area base wrong");

	c_error: cover property (rsp_valid && rsp_error);
	c_retry: cover property (cmd_valid && err_run == 2'h1);
	c_data_ok: cover property (rsp_valid && !rsp_error
		&& last_addr >= PIUS_ADDR_DATA);
endmodule
`default_nettype wire

/* tb/param_image_upload_seq_test.sv */
// Self-checking bench for host and drive ends of the upload link
`timescale 1ns/10ps
`default_nettype none
module param_image_upload_seq_test
	import pius_pkg::*;
();
	logic                  mclk, rst_n, start;
	logic                  img_wr_en, len_wr_en, servo_on_req;
	logic [PIUS_IDX_W-1:0] img_wr_idx;
	logic [31:0]           img_wr_data, word_data;
	logic [15:0]           len_wr_data, word_index, image_length;
	logic                  busy, done, aborted, word_valid;
	int                    n_fail, total_checks, seed, wcnt, j;
	int                    lens [4] = '{0, 5, 8, 2046};
	logic [31:0]           mdl [0:PIUS_MEM_WORDS-1];
	logic [31:0]           exp_q [$];

	// ==========================================================
	// Design and checker
	pius_link_if lnk ();
	pius_host #(.TIMEOUT_CYC(64)) u_pius_host (.mclk(mclk), .rst_n(rst_n),
		.lnk(lnk), .start(start), .busy(busy), .done(done), .aborted(aborted),
		.word_valid(word_valid), .word_data(word_data),
		.word_index(word_index), .image_length(image_length));
	pius_drive u_pius_drive (.mclk(mclk), .rst_n(rst_n), .lnk(lnk),
		.img_wr_en(img_wr_en), .img_wr_idx(img_wr_idx),
		.img_wr_data(img_wr_data), .len_wr_en(len_wr_en),
		.len_wr_data(len_wr_data), .servo_on_req(servo_on_req));
	pius_link_asserts u_pius_link_asserts (.mclk(mclk), .rst_n(rst_n),
		.cmd_valid(lnk.cmd_valid), .cmd_code(lnk.cmd_code),
		.cmd_mode(lnk.cmd_mode), .cmd_size(lnk.cmd_size),
		.cmd_addr(lnk.cmd_addr), .servo_off_cmd(lnk.servo_off_cmd),
		.rsp_valid(lnk.rsp_valid),
		.response_command_code(lnk.response_command_code),
		.command_ready_flag(lnk.command_ready_flag),
		.rsp_error(lnk.rsp_error), .servo_on(lnk.servo_on));

	// Clock
	always #2 mclk = ~mclk;

	// ==========================================================
	// Compare and closing tasks
	task automatic chk32(input string what, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", what, e, g);
		end
	endtask
	task automatic chk1(input string what, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s exp %b got %b", what, e, g);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// Watch commands on the wire and image words from the host
	always @(negedge mclk) begin
		if (lnk.cmd_valid === 1'b1) begin
			if (exp_q.size() == 0) chk1("cmd expected", 1'b0, 1'b1);
			else chk32("cmd_addr", exp_q.pop_front(), lnk.cmd_addr);
		end
		if (word_valid === 1'b1) begin
			chk32("word_data", mdl[wcnt], word_data);
			wcnt++;
			chk32("word_index", wcnt, {16'h0, word_index});
		end
	end

	// Load image words, then the length and servo on in the same cycle
	task automatic load(input int len);
		int i;
		for (i = 0; i < len / 2; i++) begin
			@(posedge mclk);
			mdl[i] = $random(seed);
			img_wr_en <= 1'b1;
			img_wr_idx <= i[PIUS_IDX_W-1:0];
			img_wr_data <= mdl[i];
		end
		@(posedge mclk);
		img_wr_en <= 1'b0;
		len_wr_en <= 1'b1;
		len_wr_data <= len[15:0];
		servo_on_req <= 1'b1;
		@(posedge mclk);
		len_wr_en <= 1'b0;
		servo_on_req <= 1'b0;
		@(negedge mclk);
		chk1("servo_on", 1'b1, lnk.servo_on);
	endtask

	// Run one upload; brk shrinks the length mid-run to force failures
	task automatic upload(input int len, input bit brk, input string name);
		int i, k;
		exp_q.delete();
		wcnt = 0;
		exp_q.push_back(PIUS_ADDR_LEN);
		for (i = 0; i < (brk ? 3 : len / 2); i++) begin
			exp_q.push_back(PIUS_ADDR_DATA + PIUS_ADDR_STEP * i);
		end
		if (brk) exp_q.push_back(PIUS_ADDR_DATA + 32'h8);
		@(posedge mclk);
		start <= 1'b1;
		@(posedge mclk);
		start <= 1'b0;
		@(negedge mclk);
		chk1("busy", 1'b1, busy);
		chk1("servo_off_cmd", 1'b1, lnk.servo_off_cmd);
		@(posedge mclk);
		start <= 1'b1;
		@(posedge mclk);
		start <= 1'b0;
		k = 0;
		while (done !== 1'b1 && aborted !== 1'b1 && k < 20000) begin
			@(negedge mclk);
			k++;
			if (brk && wcnt == 1) begin
				@(posedge mclk);
				len_wr_en <= 1'b1;
				len_wr_data <= 16'h0004;
				@(posedge mclk);
				len_wr_en <= 1'b0;
			end
		end
		chk1("done", !brk, done);
		chk1("aborted", brk, aborted);
		chk1("busy end", 1'b0, busy);
		@(negedge mclk);
		chk1("servo released", 1'b0, lnk.servo_off_cmd);
		chk32("image_length", len, {16'h0, image_length});
		chk32("words", brk ? 2 : len / 2, wcnt);
		chk32("cmds left", 0, exp_q.size());
		$display("%s len %0d finished", name, len);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		{start, img_wr_en, len_wr_en, servo_on_req} = 4'h0;
		img_wr_idx = '0;
		img_wr_data = 32'h0;
		len_wr_data = 16'h0;
		seed = 46614;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		@(negedge mclk);
		chk1("ready idle", 1'b1, lnk.command_ready_flag);
		load(8);
		upload(8, 1'b1, "abort");
		for (j = 0; j < 4; j++) begin
			load(lens[j]);
			upload(lens[j], 1'b0, "upload");
		end
		end_sim;
	end

	// Watchdog
	initial begin
		repeat (40000) @(posedge mclk);
		n_fail++;
		end_sim;
	end
endmodule
`default_nettype wire
